//--- design/port_bus_if.sv
// design: pin interface of the single-chip microcomputer (ports, bus, irqs, serial)
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module port_bus_if
  import port_bus_pkg::*;
(
  input wire logic sys_clk, // system clock, stands for the crystal input
  input wire logic rst, // asynchronous reset, active high
  input wire logic clkEn, // freezes all state while low
  input wire logic [3:0] regAddr, // register address
  input wire logic [7:0] regWdata, // register write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after the strobe
  input wire bus_req_t busReq, // core bus request, held until busDone
  output logic busDone, // one-cycle pulse closing a bus cycle
  output logic [7:0] busRdata, // byte read from the data bus (to accumulator)
  output logic periphClk, // half-rate peripheral clock
  output pin8_t port_a, // port A pins
  input wire logic [7:0] portBIn, // port B pin levels
  output pin8_t port_b, // port B pin drive
  input wire logic [7:0] portCIn, // port C pin levels
  output pin8_t port_c, // port C pin drive
  input wire logic serialAckFn, // acknowledge level for the port C control line
  input wire logic timerOutFn, // timer output level for port C
  input wire logic busGrantFn, // bus grant level for port C
  output logic serialChipSelect, // serial chip select seen on port C
  output logic busHoldReq, // bus request seen on port C
  output logic [15:0] port_e, // port E pins
  input wire logic [7:0] extDataIn, // data bus pin levels
  output logic [7:0] extDataOut, // data bus drive value
  output logic extDataOe, // data bus drive enable
  output logic rdStrobeN, // read strobe, active low
  output logic wrStrobeN, // write strobe, active low
  output logic first_cycle_marker, // high during opcode fetch T1..T3
  input wire logic waitReqN, // wait request, active low
  input wire logic level_irq_in, // level interrupt input
  input wire logic rising_irq_in, // rising edge interrupt input
  input wire logic programmable_edge_irq_in, // programmable edge interrupt input
  input wire logic timer_internal_irq, // internal timer request
  input wire logic serial_internal_irq, // internal serial request
  input wire logic irqAck, // core takes the pending request
  output irq_src_t irqSrc, // highest priority pending request
  input wire logic serClk, // serial clock level
  input wire logic serIn, // serial input
  output logic serOut // serial output
);

  typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_WAIT, ST_T3} bus_st_t;

  function automatic logic [FILT_W-1:0] filtStep(input logic lvl, input logic [FILT_W-1:0] cnt);
    if (!lvl) begin
      filtStep = '0;
    end else if (cnt != FILT_MAX) begin
      filtStep = cnt + FILT_W'(1);
    end else begin
      filtStep = cnt;
    end
  endfunction : filtStep

  logic [7:0] portA_r, portB_r, dirB_r, portC_r, funcC_r, peHi_r, peLo_r, mask_r, ser_r;
  logic [1:0] peMode_r;
  logic [2:0] serCnt_r;
  logic serDone_r;
  logic periphClk_r;
  logic regWin;
  assign regWin = clkEn & regWr;

  // half-rate clock for external parts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periphClk_r <= 1'b0;
    end else if (clkEn) begin
      periphClk_r <= ~periphClk_r;
    end
  end
  assign periphClk = periphClk_r;

  // port A latch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portA_r <= ZERO8;
    end else if (regWin && regAddr == OFS_PORT_A) begin
      portA_r <= regWdata;
    end
  end
  assign port_a.out = portA_r;
  assign port_a.oe = 8'hFF;

  // port B latch: outputs from writes, inputs captured from pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portB_r <= ZERO8;
      dirB_r <= DIR_B_RST;
    end else if (clkEn) begin
      if (regWr && regAddr == OFS_DIR_B) begin
        dirB_r <= regWdata;
      end
      for (int i = 0; i < 8; i++) begin
        if (dirB_r[i]) begin
          portB_r[i] <= portBIn[i];
        end else if (regWr && regAddr == OFS_PORT_B) begin
          portB_r[i] <= regWdata[i];
        end
      end
    end
  end
  assign port_b.out = portB_r;
  assign port_b.oe = ~dirB_r;

  // port C plain latch and function select
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portC_r <= ZERO8;
      funcC_r <= FUNC_C_RST;
    end else if (clkEn && regWr) begin
      if (regAddr == OFS_PORT_C) begin
        portC_r <= regWdata;
      end
      if (regAddr == OFS_FUNC_C) begin
        funcC_r <= regWdata;
      end
    end
  end

  logic memIoSel_r;
  always_comb begin
    port_c.out = portC_r;
    port_c.oe = 8'h00;
    port_c.oe[0] = ~funcC_r[0];
    port_c.oe[1] = ~funcC_r[1];
    for (int i = PC_SAK; i <= PC_GRANT; i++) begin
      port_c.oe[i] = 1'b1;
    end
    if (!funcC_r[PC_SAK]) port_c.out[PC_SAK] = serialAckFn;
    if (!funcC_r[PC_TO]) port_c.out[PC_TO] = timerOutFn;
    if (!funcC_r[PC_IOM]) port_c.out[PC_IOM] = memIoSel_r;
    if (!funcC_r[PC_GRANT]) port_c.out[PC_GRANT] = busGrantFn;
  end
  assign serialChipSelect = ~funcC_r[PC_SCS] & portCIn[PC_SCS];
  assign busHoldReq = ~funcC_r[PC_HOLD] & portCIn[PC_HOLD];

  // port E mode and output words
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      peMode_r <= PE_ADDR16;
      peHi_r <= ZERO8;
      peLo_r <= ZERO8;
    end else if (regWin) begin
      if (regAddr == OFS_PE_MODE && regWdata[1:0] <= PE_OUT16) begin
        peMode_r <= regWdata[1:0];
      end
      if (regAddr == OFS_PE_HI) begin
        peHi_r <= regWdata;
      end
      if (regAddr == OFS_PE_LO) begin
        peLo_r <= regWdata;
      end
    end
  end

  // bus cycle sequencer
  bus_st_t busSt_r;
  logic [15:0] addr_r;
  logic [7:0] busRdata_r;
  logic busWr_r, busFetch_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busSt_r <= ST_IDLE;
      addr_r <= '0;
      busWr_r <= 1'b0;
      busFetch_r <= 1'b0;
      memIoSel_r <= 1'b0;
      busRdata_r <= ZERO8;
      extDataOut <= ZERO8;
    end else if (clkEn) begin
      case (busSt_r)
        ST_IDLE: begin
          if (busReq.req) begin
            busSt_r <= ST_T1;
            addr_r <= busReq.addr;
            busWr_r <= busReq.wr;
            busFetch_r <= busReq.fetch;
            memIoSel_r <= busReq.ioSel;
            extDataOut <= busReq.data;
          end
        end
        ST_T1: busSt_r <= ST_T2;
        ST_T2, ST_WAIT: begin
          busSt_r <= waitReqN ? ST_T3 : ST_WAIT;
        end
        ST_T3: begin
          busSt_r <= ST_IDLE;
          if (!busWr_r) begin
            busRdata_r <= extDataIn;
          end
        end
        default: busSt_r <= ST_IDLE;
      endcase
    end
  end
  logic inCycle;
  assign inCycle = busSt_r != ST_IDLE;
  assign busDone = clkEn && busSt_r == ST_T3;
  assign busRdata = busRdata_r;
  assign first_cycle_marker = inCycle && busFetch_r;
  assign rdStrobeN = ~(inCycle && busSt_r != ST_T1 && !busWr_r);
  assign wrStrobeN = ~(inCycle && busSt_r != ST_T1 && busWr_r);
  assign extDataOe = inCycle && busWr_r;

  always_comb begin
    case (peMode_r)
      PE_OUT16: port_e = {peHi_r, peLo_r};
      PE_NIB_ADDR12: port_e = {peHi_r[7:4], addr_r[11:0]};
      default: port_e = addr_r;
    endcase
  end

  // interrupt conditioning
  logic [FILT_W-1:0] f0Hi_r, f1Hi_r, f1Lo_r, f2Hi_r, f2Lo_r;
  logic q0_r, q1_r, q2_r, q1d_r, q2d_r;
  logic pendRise_r, pendProg_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      f0Hi_r <= '0;
      f1Hi_r <= '0;
      f1Lo_r <= '0;
      f2Hi_r <= '0;
      f2Lo_r <= '0;
    end else if (clkEn) begin
      f0Hi_r <= filtStep(level_irq_in, f0Hi_r);
      f1Hi_r <= filtStep(rising_irq_in, f1Hi_r);
      f1Lo_r <= filtStep(~rising_irq_in, f1Lo_r);
      f2Hi_r <= filtStep(programmable_edge_irq_in, f2Hi_r);
      f2Lo_r <= filtStep(~programmable_edge_irq_in, f2Lo_r);
    end
  end

  // filtered levels: q1_r and q2_r change only once a level has stood for the full time; q0_r waits only to rise and clears a cycle after its counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q0_r <= 1'b0;
      q1_r <= 1'b0;
      q2_r <= 1'b0;
      q1d_r <= 1'b0;
      q2d_r <= 1'b0;
    end else if (clkEn) begin
      q0_r <= (f0Hi_r == FILT_MAX);
      if (f1Hi_r == FILT_MAX) q1_r <= 1'b1;
      else if (f1Lo_r == FILT_MAX) q1_r <= 1'b0;
      if (f2Hi_r == FILT_MAX) q2_r <= 1'b1;
      else if (f2Lo_r == FILT_MAX) q2_r <= 1'b0;
      q1d_r <= q1_r;
      q2d_r <= q2_r;
    end
  end

  logic riseEv, progEv;
  assign riseEv = q1_r & ~q1d_r;
  assign progEv = mask_r[ES_BIT] ? (q2_r & ~q2d_r) : (~q2_r & q2d_r);

  // edge requests are sticky; a new edge wins over the acknowledge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pendRise_r <= 1'b0;
      pendProg_r <= 1'b0;
    end else if (clkEn) begin
      pendRise_r <= riseEv | (pendRise_r & ~(irqAck && irqSrc == IRQ_RISE));
      pendProg_r <= progEv | (pendProg_r & ~(irqAck && irqSrc == IRQ_PROG));
    end
  end

  always_comb begin
    if (q0_r) irqSrc = IRQ_LEVEL;
    else if (timer_internal_irq) irqSrc = IRQ_TIMER;
    else if (pendRise_r) irqSrc = IRQ_RISE;
    else if (pendProg_r) irqSrc = IRQ_PROG;
    else if (serial_internal_irq) irqSrc = IRQ_SERIAL;
    else irqSrc = IRQ_NONE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r <= ZERO8;
    end else if (regWin && regAddr == OFS_MASK) begin
      mask_r <= regWdata;
    end
  end

  // serial shifter, clock sampled synchronously
  logic serClkD_r, serOut_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serClkD_r <= 1'b1; // serial clock idles high, so no false rise after reset
      ser_r <= ZERO8;
      serCnt_r <= '0;
      serDone_r <= 1'b0;
      serOut_r <= 1'b0;
    end else if (clkEn) begin
      serClkD_r <= serClk;
      if (serClk && !serClkD_r) begin
        ser_r <= {ser_r[6:0], serIn};
        serCnt_r <= serCnt_r + 3'h1;
        if (serCnt_r == SER_LAST) serDone_r <= 1'b1;
      end else if (!serClk && serClkD_r) begin
        serOut_r <= ser_r[7];
      end else if (regWr && regAddr == OFS_SER) begin
        ser_r <= regWdata;
        serCnt_r <= '0;
        serDone_r <= 1'b0;
      end
    end
  end
  assign serOut = serOut_r;

  // register read port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdata <= ZERO8;
    end else if (clkEn) begin
      if (regRd) begin
        case (regAddr)
          OFS_PORT_A: regRdata <= portA_r;
          OFS_PORT_B: regRdata <= portB_r;
          OFS_DIR_B: regRdata <= dirB_r;
          OFS_PORT_C: regRdata <= (portCIn & ~port_c.oe) | (portC_r & port_c.oe);
          OFS_FUNC_C: regRdata <= funcC_r;
          OFS_PE_MODE: regRdata <= {6'h00, peMode_r};
          OFS_PE_HI: regRdata <= peHi_r;
          OFS_PE_LO: regRdata <= peLo_r;
          OFS_MASK: regRdata <= mask_r;
          OFS_IRQ: regRdata <= {5'h00, irqSrc};
          OFS_SER: regRdata <= ser_r;
          OFS_STAT: regRdata <= {6'h00, serDone_r, inCycle};
          default: regRdata <= ZERO8;
        endcase
      end else begin
        regRdata <= ZERO8;
      end
    end
  end

  a_periph_toggle: assert property (@(posedge sys_clk) disable iff (rst)
    clkEn && !rst |=> periphClk != $past(periphClk)) else $error("peripheral clock did not toggle");
  a_port_a_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(regWr && clkEn && regAddr == OFS_PORT_A) |=> $stable(port_a.out)) else $error("port A changed");
  a_dir_b_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && regWr && regAddr == OFS_DIR_B) |=> port_b.oe == ~$past(regWdata)) else $error("port B enable wrong");
  a_wait_stall: assert property (@(posedge sys_clk) disable iff (rst)
    (clkEn && busSt_r == ST_T2 && !waitReqN) |=> busSt_r == ST_WAIT) else $error("wait ignored");
  a_rd_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    (busSt_r == ST_T3 && !busWr_r) |-> !rdStrobeN && wrStrobeN) else $error("read strobe wrong");
  a_wr_strobe: assert property (@(posedge sys_clk) disable iff (rst)
    (busSt_r == ST_T2 && busWr_r) |-> !wrStrobeN && extDataOe) else $error("write strobe wrong");
  a_irq_priority: assert property (@(posedge sys_clk) disable iff (rst)
    $past(clkEn) && $past(f0Hi_r) == FILT_MAX |-> irqSrc == IRQ_LEVEL) else $error("level priority lost");
  a_pe_out16: assert property (@(posedge sys_clk) disable iff (rst)
    peMode_r == PE_OUT16 |-> port_e == {peHi_r, peLo_r}) else $error("port E output wrong");
  a_filter_time: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(q0_r) |-> $past(f0Hi_r) == FILT_MAX) else $error("filter too short");
  c_read_cycle: cover property (@(posedge sys_clk) busSt_r == ST_T3 && !busWr_r);
  c_wait_cycle: cover property (@(posedge sys_clk) busSt_r == ST_WAIT);
  c_serial_byte: cover property (@(posedge sys_clk) $rose(serDone_r));
endmodule : port_bus_if

//--- design/port_bus_pkg.sv
// package: constants and carrier types for the pin interface block
package port_bus_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int IRQ_FILTER_NS = 4000;
  localparam int IRQ_FILTER_CYC = (IRQ_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = 10;
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(IRQ_FILTER_CYC);
  // register offsets
  localparam logic [3:0] OFS_PORT_A = 4'h0;
  localparam logic [3:0] OFS_PORT_B = 4'h1;
  localparam logic [3:0] OFS_DIR_B = 4'h2;
  localparam logic [3:0] OFS_PORT_C = 4'h3;
  localparam logic [3:0] OFS_FUNC_C = 4'h4;
  localparam logic [3:0] OFS_PE_MODE = 4'h5;
  localparam logic [3:0] OFS_PE_HI = 4'h6;
  localparam logic [3:0] OFS_PE_LO = 4'h7;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_IRQ = 4'h9;
  localparam logic [3:0] OFS_SER = 4'hA;
  localparam logic [3:0] OFS_STAT = 4'hB;
  localparam logic [7:0] DIR_B_RST = 8'hFF;
  localparam logic [7:0] FUNC_C_RST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int ES_BIT = 0;
  localparam int PC_SCS = 2;
  localparam int PC_SAK = 3;
  localparam int PC_TO = 4;
  localparam int PC_IOM = 5;
  localparam int PC_GRANT = 6;
  localparam int PC_HOLD = 7;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic [3:0] NIB_MASK_ZERO = 4'h0;
  typedef enum logic [1:0] {PE_ADDR16, PE_NIB_ADDR12, PE_OUT16} pe_mode_t;
  typedef enum logic [2:0] {IRQ_NONE, IRQ_LEVEL, IRQ_TIMER, IRQ_RISE, IRQ_PROG, IRQ_SERIAL} irq_src_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic fetch;
    logic ioSel;
    logic [15:0] addr;
    logic [7:0] data;
  } bus_req_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin8_t;
endpackage : port_bus_pkg

//--- test/ext_bus_partner.sv
// far-side memory model: answers reads and inserts wait states
`timescale 1ns/1ps
module ext_bus_partner (
  input wire logic sys_clk, // system clock
  input wire logic rst, // reset, active high
  input wire logic rdStrobeN, // read strobe from the block
  input wire logic wrStrobeN, // write strobe from the block
  input wire logic [3:0] nWait, // wait cycles per access
  input wire logic [7:0] rdData, // byte returned on reads
  output logic waitReqN, // wait request, active low
  output logic [7:0] extDataIn // data bus level seen by the block
);
  logic [3:0] cnt_r;
  logic [7:0] last_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      last_r <= 8'h00;
    end else begin
      cnt_r <= (rdStrobeN && wrStrobeN) ? 4'h0 : cnt_r + 4'h1;
      last_r <= extDataIn;
    end
  end
  // hold the access low until the requested waits are used up
  assign waitReqN = !(!(rdStrobeN && wrStrobeN) && cnt_r < nWait);
  // released bus keeps changing so a stale byte never passes for data
  assign extDataIn = rdStrobeN ? ~last_r : rdData;
endmodule : ext_bus_partner

//--- test/mcu_port_bus_interface_bench.sv
// self-checking bench for the pin interface block
`timescale 1ns/1ps
module mcu_port_bus_interface_bench;
  import port_bus_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0, irqAck = 1'b0;
  logic [3:0] regAddr = 4'h0, nWait = 4'h0;
  logic [7:0] regWdata = 8'h00, portBIn = 8'h00, portCIn = 8'h00, rdData = 8'h00;
  logic serialAckFn = 1'b0, timerOutFn = 1'b0, busGrantFn = 1'b0, serClk = 1'b1, serIn = 1'b0;
  logic level_irq_in = 1'b0, rising_irq_in = 1'b0, programmable_edge_irq_in = 1'b0;
  logic timer_internal_irq = 1'b0, serial_internal_irq = 1'b0;
  bus_req_t busReq = '0;
  logic [7:0] regRdata, busRdata, extDataIn, extDataOut, a, d, v, p, h, l;
  logic busDone, periphClk, serialChipSelect, busHoldReq, extDataOe, rdStrobeN, wrStrobeN;
  logic first_cycle_marker, waitReqN, serOut, pc, rdPend = 1'b0, busPend = 1'b0;
  logic [15:0] port_e;
  pin8_t port_a, port_b, port_c;
  irq_src_t irqSrc;
  logic [7:0] expQ[$];
  int n_mismatch = 0, num_checks = 0;

  port_bus_if uut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .busReq(busReq), .busDone(busDone),
    .busRdata(busRdata), .periphClk(periphClk), .port_a(port_a), .portBIn(portBIn), .port_b(port_b),
    .portCIn(portCIn), .port_c(port_c), .serialAckFn(serialAckFn), .timerOutFn(timerOutFn),
    .busGrantFn(busGrantFn), .serialChipSelect(serialChipSelect), .busHoldReq(busHoldReq),
    .port_e(port_e), .extDataIn(extDataIn), .extDataOut(extDataOut), .extDataOe(extDataOe),
    .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN), .first_cycle_marker(first_cycle_marker),
    .waitReqN(waitReqN), .level_irq_in(level_irq_in), .rising_irq_in(rising_irq_in),
    .programmable_edge_irq_in(programmable_edge_irq_in), .timer_internal_irq(timer_internal_irq),
    .serial_internal_irq(serial_internal_irq), .irqAck(irqAck), .irqSrc(irqSrc), .serClk(serClk),
    .serIn(serIn), .serOut(serOut));
  ext_bus_partner far (.sys_clk(sys_clk), .rst(rst), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN),
    .nWait(nWait), .rdData(rdData), .waitReqN(waitReqN), .extDataIn(extDataIn));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic regW(input logic [3:0] ad, input logic [7:0] dat);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= dat;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : regW

  task automatic regR(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= ad;
    expQ.push_back(exp);
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask : regR

  task automatic bus(input logic wr, input logic fetch, input logic [15:0] ad, input logic [7:0] dat,
      input logic [3:0] w);
    int n;
    n = 0;
    nWait <= w;
    rdData <= dat;
    busReq <= '{req: 1'b1, wr: wr, fetch: fetch, ioSel: 1'b0, addr: ad, data: dat};
    do begin
      @(posedge sys_clk);
      n++;
      check(8'(first_cycle_marker), 8'(fetch && n >= 2));
      check(8'(rdStrobeN), 8'(!(!wr && n >= 3)));
      check(8'(wrStrobeN), 8'(!(wr && n >= 3)));
      if (n == 2) check(port_e[15:8], ad[15:8]);
      if (n == 2) check(port_e[7:0], ad[7:0]);
    end while (!busDone && n < 40);
    if (!wr) expQ.push_back(dat);
    else check(extDataOut, dat);
    if (wr) check(8'(extDataOe), 8'h01);
    check(8'(n), 8'(4 + w));
    busReq.req <= 1'b0;
    @(posedge sys_clk);
    check(8'({rdStrobeN, wrStrobeN}), 8'h03);
  endtask : bus

  task automatic irqStep(input int n, input irq_src_t e);
    cyc(n);
    check(8'(irqSrc), 8'(e));
  endtask : irqStep

  // read results are paired with the oldest expectation in the cycle they stand
  always @(posedge sys_clk) begin
    if (rdPend || busPend) check(rdPend ? regRdata : busRdata, expQ.pop_front());
    rdPend <= regRd;
    busPend <= busDone && !busReq.wr;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    cyc(60000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hEF0FB140));
    cyc(20);
    rst <= 1'b0;
    regR(OFS_DIR_B, DIR_B_RST);
    regR(OFS_FUNC_C, FUNC_C_RST);
    regR(OFS_PORT_A, ZERO8);
    for (int i = 0; i < 6; i++) begin
      pc = periphClk;
      cyc(1);
      check(8'(periphClk), 8'(!pc));
    end
    clkEn <= 1'b0;
    cyc(1);
    pc = periphClk;
    cyc(3);
    check(8'(periphClk), 8'(pc));
    clkEn <= 1'b1;
    a = 8'($urandom);
    regW(OFS_PORT_A, a);
    cyc(1);
    check(port_a.out, a);
    check(port_a.oe, 8'hFF);
    regR(OFS_PORT_A, a);
    d = 8'($urandom);
    v = 8'($urandom);
    p = 8'($urandom);
    portBIn <= p;
    regW(OFS_DIR_B, d);
    regW(OFS_PORT_B, v);
    cyc(1);
    check(port_b.oe, ~d);
    check(port_b.out & ~d, v & ~d);
    regR(OFS_PORT_B, (v & ~d) | (p & d));
    check(port_a.out, a);
    portCIn <= 8'($urandom);
    serialAckFn <= 1'b1;
    busGrantFn <= 1'b1;
    regW(OFS_FUNC_C, 8'h00);
    cyc(2);
    check(port_c.oe, 8'h7B);
    check(8'({port_c.out[6], port_c.out[5], port_c.out[4], port_c.out[3]}), 8'h09);
    check(8'({busHoldReq, serialChipSelect}), 8'({portCIn[7], portCIn[2]}));
    regW(OFS_FUNC_C, 8'hFF);
    cyc(1);
    check(port_c.oe, 8'h78);
    regR(OFS_PORT_C, portCIn & 8'h87);
    regW(4'hF, 8'hA5);
    regR(4'hF, ZERO8);
    bus(1'b0, 1'b1, 16'($urandom), 8'($urandom), 4'h0);
    bus(1'b0, 1'b0, 16'($urandom), 8'($urandom), 4'h3);
    bus(1'b1, 1'b0, 16'($urandom), 8'($urandom), 4'h2);
    bus(1'b1, 1'b0, 16'($urandom), 8'($urandom), 4'h0);
    h = 8'($urandom);
    l = 8'($urandom);
    regW(OFS_PE_HI, h);
    regW(OFS_PE_LO, l);
    regW(OFS_PE_MODE, 8'h02);
    cyc(1);
    check(port_e[15:8], h);
    check(port_e[7:0], l);
    regW(OFS_PE_MODE, 8'h01);
    cyc(1);
    check(8'(port_e[15:12]), 8'(h[7:4]));
    regW(OFS_PE_MODE, 8'h03);
    cyc(1);
    check(8'(port_e[15:12]), 8'(h[7:4]));
    // serial clock idles high, so the first edge of a frame is a fall
    regW(OFS_SER, h);
    for (int i = 7; i >= 0; i--) begin
      serClk <= 1'b0;
      cyc(4);
      check(8'(serOut), 8'(h[i]));
      serIn <= l[i];
      cyc(4);
      serClk <= 1'b1;
      cyc(4);
    end
    regR(OFS_SER, l);
    regR(OFS_STAT, 8'h02);
    // the first 400-cycle pulse falls short of the 800-cycle filter span; later levels hold 830 cycles, just past it
    rising_irq_in <= 1'b1;
    cyc(400);
    rising_irq_in <= 1'b0;
    irqStep(830, IRQ_NONE);
    rising_irq_in <= 1'b1;
    irqStep(830, IRQ_RISE);
    serial_internal_irq <= 1'b1;
    irqStep(2, IRQ_RISE);
    timer_internal_irq <= 1'b1;
    irqStep(2, IRQ_TIMER);
    level_irq_in <= 1'b1;
    irqStep(830, IRQ_LEVEL);
    level_irq_in <= 1'b0;
    irqStep(830, IRQ_TIMER);
    timer_internal_irq <= 1'b0;
    irqStep(2, IRQ_RISE);
    irqAck <= 1'b1;
    cyc(1);
    irqAck <= 1'b0;
    irqStep(2, IRQ_SERIAL);
    serial_internal_irq <= 1'b0;
    regW(OFS_MASK, 8'h01);
    programmable_edge_irq_in <= 1'b1;
    irqStep(830, IRQ_PROG);
    irqAck <= 1'b1;
    cyc(1);
    irqAck <= 1'b0;
    irqStep(2, IRQ_NONE);
    regW(OFS_MASK, 8'h00);
    programmable_edge_irq_in <= 1'b0;
    irqStep(830, IRQ_PROG);
    cyc(4);
    finish_test();
  end
endmodule : mcu_port_bus_interface_bench
